//--- pic_top.sv
// Prioritized interrupt controller: registers, arbitration, core hand-off
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`include "pic_cfg.svh"

// What this block does
// R01: Takes sixteen request sources and arbitrates them over three levels.
// R02: Enabled power-fail beats everything and vectors to 33h.
// R03: Other sources are high or low per register; high served first.
// R04: Equal-level ties go to smallest natural priority number, 1 to 16.
// R05: Newer sources rank below external, timer and serial sources.
// R06: Serial 0 request is transmit-done OR receive-done; vector 23h, rank 6.
// R07: Conversion done vectors to 4Bh, rank 10, extended bit 1.
// R08: Power-management buffer full vectors to 63h, rank 13, extended bit 4.
// R09: Request needs its flag and its enable bit set together.
// R10: Acknowledge presents vector, blocks same or lower level until return.
module pic_top
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  // Asynchronous request pins
  input  wire logic        power_fail_request_i,
  input  wire logic        ext0_pin_i,
  input  wire logic        ext1_pin_i,
  // Peripheral flags on this clock
  input  wire logic        timer0_flag_i,
  input  wire logic        timer1_flag_i,
  input  wire logic        serial0_tx_done_flag_i,
  input  wire logic        serial0_rx_done_flag_i,
  input  wire logic        timer2_flag_i,
  input  wire logic        activity_flag_i,
  input  wire logic        twowire_flag_i,
  input  wire logic        conversion_done_request_i,
  input  wire logic        mouse_flag_i,
  input  wire logic        keyboard_flag_i,
  input  wire logic        pm_input_buffer_full_flag_i,
  input  wire logic        key_detect_flag_i,
  input  wire logic        watchdog_flag_i,
  input  wire logic        detached_kb_flag_i,
  // Processor core side
  input  wire logic        core_ack_i,
  input  wire logic        core_return_i,
  output logic             int_req_o,
  output logic      [7:0]  int_vector_o,
  // Interrupt to software
  output logic             irq_o
);

  localparam int N = `PIC_NSRC;

  // Control registers
  logic [`PIC_BASE_W-1:0] base_enable_reg_q;
  logic [`PIC_BASE_W-1:0] base_priority_reg_q;
  logic [7:0]             extended_enable_reg_q;
  logic [7:0]             extended_priority_reg_q;
  logic                   power_fail_request_enable_q;
  logic [`PIC_EV_W-1:0]   istat_q;
  logic [`PIC_EV_W-1:0]   imask_q;
  // Service state
  pic_state_t             state_q;
  pic_src_t               src_q;
  logic                   src_hi_q;
  logic [2:0]             svc_q;
  // Request path
  logic [2:0]             pins_sync;
  logic                   serial0_request;
  logic                   pm_buffer_request;
  logic [N-1:0]           flag_vec;
  logic [N-1:0]           en_vec;
  logic [N-1:0]           hi_vec;
  logic [N-1:0]           pend_vec;
  logic                   win_valid;
  pic_src_t               win_src;
  pic_level_t             win_level;
  pic_level_t             cur_level;
  logic                   win_ok;
  logic                   take;
  logic                   ret;
  logic [`PIC_EV_W-1:0]   ev_set;
  logic [7:0]             rdata_d;

  // Pins cross into the clock domain
  pic_sync #(
    .W (3)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({ext1_pin_i, ext0_pin_i, power_fail_request_i}),
    .q_o       (pins_sync)
  );

  // Combined source requests
  assign serial0_request   = serial0_tx_done_flag_i
                           | serial0_rx_done_flag_i;          // R06
  assign pm_buffer_request = pm_input_buffer_full_flag_i;     // R08

  // Flags in natural priority order, index 0 is power fail
  assign flag_vec = {detached_kb_flag_i, watchdog_flag_i,
                     key_detect_flag_i, pm_buffer_request,
                     keyboard_flag_i, mouse_flag_i,
                     conversion_done_request_i, twowire_flag_i,
                     activity_flag_i, timer2_flag_i, serial0_request,
                     timer1_flag_i, pins_sync[2], timer0_flag_i,
                     pins_sync[1], pins_sync[0]};              // R01 R05

  // Enable and level maps; newer sources live in extended registers
  assign en_vec = {extended_enable_reg_q, base_enable_reg_q,
                   power_fail_request_enable_q};              // R07 R08
  assign hi_vec = {extended_priority_reg_q, base_priority_reg_q,
                   1'b0};                                     // R03 R07
  assign pend_vec = flag_vec & en_vec;                        // R09

  // Winner among pending sources
  pic_arbiter #(
    .N (N)
  ) u_arb (
    .pend_i      (pend_vec),
    .high_i      (hi_vec),
    .win_valid_o (win_valid),
    .win_src_o   (win_src),
    .win_level_o (win_level)
  );

  // Highest level now in service
  always_comb begin
    cur_level = PIC_LVL_NONE;
    if (svc_q[2]) begin
      cur_level = PIC_LVL_PF;
    end else if (svc_q[1]) begin
      cur_level = PIC_LVL_HIGH;
    end else if (svc_q[0]) begin
      cur_level = PIC_LVL_LOW;
    end
  end

  assign win_ok = win_valid && (win_level > cur_level);       // R10
  assign take   = core_ack_i && (state_q == PIC_ST_OFFER);
  assign ret    = core_return_i;

  // Offer sequencer, re-arbitrated every cycle while offering
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q      <= PIC_ST_IDLE;
      int_req_o    <= 1'b0;
      int_vector_o <= 8'h00;
      src_q        <= 4'h0;
      src_hi_q     <= 1'b0;
    end else begin
      case (state_q)
        PIC_ST_IDLE: begin
          if (win_ok && !ret) begin
            state_q      <= PIC_ST_OFFER;
            int_req_o    <= 1'b1;
            int_vector_o <= pic_vector(win_src);               // R02 R06
            src_q        <= win_src;
            src_hi_q     <= (win_level == PIC_LVL_HIGH);
          end
        end
        PIC_ST_OFFER: begin
          if (take || ret || !win_ok) begin
            state_q   <= PIC_ST_IDLE;
            int_req_o <= 1'b0;                                 // R10
          end else begin
            int_vector_o <= pic_vector(win_src);               // R07 R08
            src_q        <= win_src;
            src_hi_q     <= (win_level == PIC_LVL_HIGH);
          end
        end
        default: begin
          state_q   <= PIC_ST_IDLE;
          int_req_o <= 1'b0;
        end
      endcase
    end
  end

  // In-service levels: set on acknowledge, top one cleared on return
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_q <= 3'h0;
    end else if (take) begin
      if (src_q == `PIC_SRC_PF) begin
        svc_q[2] <= 1'b1;                                      // R10
      end else if (src_hi_q) begin
        svc_q[1] <= 1'b1;
      end else begin
        svc_q[0] <= 1'b1;
      end
    end else if (ret) begin
      if (svc_q[2]) begin
        svc_q[2] <= 1'b0;
      end else if (svc_q[1]) begin
        svc_q[1] <= 1'b0;
      end else begin
        svc_q[0] <= 1'b0;
      end
    end
  end

  // Control register writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_enable_reg_q           <= `PIC_BASE_W'(`PIC_RST_BYTE);
      base_priority_reg_q         <= `PIC_BASE_W'(`PIC_RST_BYTE);
      extended_enable_reg_q       <= `PIC_RST_BYTE;
      extended_priority_reg_q     <= `PIC_RST_BYTE;
      power_fail_request_enable_q <= 1'b0;
      imask_q                     <= '0;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `PIC_ADR_BASE_EN:  base_enable_reg_q <= reg_wdata_i[6:0];
        `PIC_ADR_BASE_PRI: base_priority_reg_q <= reg_wdata_i[6:0];
        `PIC_ADR_EXT_EN:   extended_enable_reg_q <= reg_wdata_i;
        `PIC_ADR_EXT_PRI:  extended_priority_reg_q <= reg_wdata_i;
        `PIC_ADR_CTRL: begin
          power_fail_request_enable_q <= reg_wdata_i[`PIC_CTRL_PFEN];
        end
        `PIC_ADR_IMASK:    imask_q <= reg_wdata_i[`PIC_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Event bits: grant, power-fail grant, return with nothing in service
  assign ev_set = {ret && (svc_q == 3'h0),
                   take && (src_q == `PIC_SRC_PF),
                   take};

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      istat_q <= '0;
    end else begin
      if (reg_we_i && (reg_addr_i == `PIC_ADR_ISTAT)) begin
        istat_q <= (istat_q & ~reg_wdata_i[`PIC_EV_W-1:0]) | ev_set;
      end else begin
        istat_q <= istat_q | ev_set;
      end
    end
  end

  // Level interrupt from registered status
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(istat_q & imask_q);
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `PIC_ADR_BASE_EN:  rdata_d = {1'b0, base_enable_reg_q};
      `PIC_ADR_BASE_PRI: rdata_d = {1'b0, base_priority_reg_q};
      `PIC_ADR_EXT_EN:   rdata_d = extended_enable_reg_q;
      `PIC_ADR_EXT_PRI:  rdata_d = extended_priority_reg_q;
      `PIC_ADR_CTRL:     rdata_d = {7'h00, power_fail_request_enable_q};
      `PIC_ADR_SVC:      rdata_d = {4'h0, int_req_o, svc_q};
      `PIC_ADR_ISTAT:    rdata_d = {5'h00, istat_q};
      `PIC_ADR_IMASK:    rdata_d = {5'h00, imask_q};
      `PIC_ADR_ACTIVE:   rdata_d = {3'h0, src_hi_q, src_q};
      default:           rdata_d = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Acknowledge followed by a cycle with the request withdrawn
  sequence s_take;
    take;
  endsequence

  sequence s_drop;
    ##1 !int_req_o;
  endsequence

  // Power fail pending and eligible is offered next with its vector
  a_pf_offer: assert property ( // R02
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pend_vec[0] && win_ok && !take && !ret)
      |=> (int_req_o && int_vector_o == `PIC_VEC_PF))
    else $error("power fail not offered first");

  // A low-level offer means no high-level source was pending
  a_high_first: assert property ( // R03
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_req_o && !src_hi_q && src_q != `PIC_SRC_PF)
      |-> ($past(pend_vec & hi_vec) == 16'h0000))
    else $error("low offered over high");

  // No better-ranked pending source of the same level was skipped
  a_tie_order: assert property ( // R04
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_req_o && src_q != `PIC_SRC_PF)
      |-> (($past(pend_vec) & (src_hi_q ? $past(hi_vec) : 16'hFFFF)
            & ((16'h0001 << src_q) - 16'h0001)) == 16'h0000))
    else $error("natural order broken");

  // Serial offer carries 23h and came from either serial flag
  a_serial_vec: assert property ( // R06
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_req_o && src_q == `PIC_SRC_SERIAL)
      |-> (int_vector_o == `PIC_VEC_SERIAL
           && $past(serial0_tx_done_flag_i || serial0_rx_done_flag_i)))
    else $error("serial vector wrong");

  // Conversion offer carries 4Bh and needed extended enable bit 1
  a_adc_vec: assert property ( // R07
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_req_o && src_q == `PIC_SRC_ADC)
      |-> (int_vector_o == `PIC_VEC_ADC
           && $past(extended_enable_reg_q[1])))
    else $error("conversion vector wrong");

  // Buffer offer carries 63h and needed extended enable bit 4
  a_pmbuf_vec: assert property ( // R08
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_req_o && src_q == `PIC_SRC_PMBUF)
      |-> (int_vector_o == `PIC_VEC_PMBUF
           && $past(extended_enable_reg_q[4])))
    else $error("buffer vector wrong");

  // An offered source had both flag and enable a cycle earlier
  a_enable_gate: assert property ( // R09
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    int_req_o |-> (($past(flag_vec & en_vec) & (16'h0001 << src_q))
                   != 16'h0000))
    else $error("disabled source offered");

  // Acknowledge withdraws the offer and marks the level in service
  a_ack_block: assert property ( // R10
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_take |-> s_drop and ##1 (svc_q != 3'h0))
    else $error("acknowledge not honoured");

  // Offers only beat the level in service
  a_level_block: assert property ( // R10
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(int_req_o) |-> $past(win_level > cur_level))
    else $error("blocked level offered");

  // Interrupt line follows masked status one cycle later
  a_irq_line: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (irq_o == $past(|(istat_q & imask_q))))
    else $error("irq line mismatch");

endmodule

//--- pic_cfg.svh
// Constants of the prioritized interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Sizes
`define PIC_NSRC       16
`define PIC_ADDR_W     4
`define PIC_DATA_W     8
`define PIC_VEC_W      8

// Register offsets
`define PIC_ADR_BASE_EN  4'h0
`define PIC_ADR_BASE_PRI 4'h1
`define PIC_ADR_EXT_EN   4'h2
`define PIC_ADR_EXT_PRI  4'h3
`define PIC_ADR_CTRL     4'h4
`define PIC_ADR_SVC      4'h5
`define PIC_ADR_ISTAT    4'h6
`define PIC_ADR_IMASK    4'h7
`define PIC_ADR_ACTIVE   4'h8

// Reset value of every control register
`define PIC_RST_BYTE     8'h00

// Field positions
`define PIC_CTRL_PFEN    0
`define PIC_EV_GRANT     0
`define PIC_EV_PF        1
`define PIC_EV_SPUR      2
`define PIC_EV_W         3
`define PIC_BASE_W       7

// Source indices, natural priority minus one
`define PIC_SRC_PF       4'h0
`define PIC_SRC_SERIAL   4'h5
`define PIC_SRC_ADC      4'h9
`define PIC_SRC_PMBUF    4'hC
`define PIC_EXT_FIRST    8

// Vector addresses
`define PIC_VEC_PF       8'h33
`define PIC_VEC_BASE     8'h03
`define PIC_VEC_STEP     8'h08
`define PIC_VEC_GAP_IDX  4'h7
`define PIC_VEC_SERIAL   8'h23
`define PIC_VEC_ADC      8'h4B
`define PIC_VEC_PMBUF    8'h63

`endif

//--- pic_pkg.sv
// Types and vector decode of the prioritized interrupt controller
`include "pic_cfg.svh"

package pic_pkg;

  // Service level, ordered so that a larger value wins
  typedef enum logic [1:0] {
    PIC_LVL_NONE,
    PIC_LVL_LOW,
    PIC_LVL_HIGH,
    PIC_LVL_PF
  } pic_level_t;

  // Offer sequencer
  typedef enum logic {
    PIC_ST_IDLE,
    PIC_ST_OFFER
  } pic_state_t;

  typedef logic [3:0] pic_src_t;

  // Fixed vector of a source; the power-fail slot sits in the gap
  function automatic logic [7:0] pic_vector(input pic_src_t s);
    logic [7:0] v;
    v = `PIC_VEC_BASE + (8'(s) - 8'h01) * `PIC_VEC_STEP;
    if (s >= `PIC_VEC_GAP_IDX) begin
      v = v + `PIC_VEC_STEP;
    end
    if (s == `PIC_SRC_PF) begin
      v = `PIC_VEC_PF;
    end
    return v;
  endfunction

endpackage

//--- pic_sync.sv
// Two-stage synchroniser for asynchronous request pins
`timescale 1ns/10ps

module pic_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

//--- pic_arbiter.sv
// Combinational three-level arbiter over the pending sources
`timescale 1ns/10ps
`include "pic_cfg.svh"

module pic_arbiter
  import pic_pkg::*;
#(
  parameter int N = `PIC_NSRC
) (
  // Pending requests and per-source high level
  input  wire logic [N-1:0] pend_i,
  input  wire logic [N-1:0] high_i,
  // Winner
  output logic              win_valid_o,
  output pic_src_t          win_src_o,
  output pic_level_t        win_level_o
);

  // Lowest set index, i.e. best natural priority
  function automatic pic_src_t first_set(input logic [N-1:0] v);
    pic_src_t r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = pic_src_t'(i);
      end
    end
    return r;
  endfunction

  logic [N-1:0] hi_pend;

  // Power fail first, then high, then low
  always_comb begin
    hi_pend     = pend_i & high_i;
    win_valid_o = |pend_i;
    win_src_o   = first_set(pend_i);               // R04 R05
    win_level_o = PIC_LVL_LOW;
    if (pend_i[`PIC_SRC_PF]) begin
      win_src_o   = `PIC_SRC_PF;                   // R02
      win_level_o = PIC_LVL_PF;
    end else if (|hi_pend) begin
      win_src_o   = first_set(hi_pend);            // R03 R04
      win_level_o = PIC_LVL_HIGH;
    end else if (!win_valid_o) begin
      win_level_o = PIC_LVL_NONE;
    end
  end

endmodule

//--- pic_core_model.sv
// Behavioural processor core that takes vectors and returns from service
`timescale 1ns/10ps

module pic_core_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Controls from the bench
  input  wire logic [3:0] ack_dly_i,
  input  wire logic       ret_go_i,
  // Controller side
  input  wire logic       req_i,
  input  wire logic [7:0] vec_i,
  output logic            ack_o,
  output logic            ret_o,
  // What the core took
  output logic            taken_o,
  output logic      [7:0] taken_vec_o
);
  logic [3:0] wait_q;

  // Acknowledge after a set wait; vector is taken at the sampling edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o       <= 1'b0;
      wait_q      <= 4'h0;
      taken_o     <= 1'b0;
      taken_vec_o <= 8'h00;
    end else begin
      taken_o <= 1'b0;
      if (ack_o) begin
        ack_o       <= 1'b0;
        taken_o     <= req_i;
        taken_vec_o <= vec_i;
        wait_q      <= 4'h0;
      end else if (req_i) begin
        if (wait_q >= ack_dly_i) begin
          ack_o <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end

  // Return from the routine one cycle after the bench asks for it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ret_o <= 1'b0;
    end else begin
      ret_o <= ret_go_i;
    end
  end
endmodule

//--- prioritized_interrupt_controller_test.sv
// Self-checking bench of the prioritized interrupt controller
`timescale 1ns/10ps
`include "pic_cfg.svh"

module prioritized_interrupt_controller_test;
  // Design and model signals
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [15:0] flags = 16'h0000;
  logic        rx_flag = 1'b0;
  logic        core_ack_i;
  logic        core_return_i;
  logic        int_req_o;
  logic [7:0]  int_vector_o;
  logic        irq_o;
  logic [3:0]  ack_dly = 4'h0;
  logic        ret_go = 1'b0;
  logic        taken;
  logic [7:0]  taken_vec;
  int          mismatches = 0;
  int          tests_run = 0;
  localparam logic [7:0] VTAB [16] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B,
    8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63, 8'h6B, 8'h73,
    8'h7B};

  // Clock
  always #5 sys_clk_i = ~sys_clk_i;

  pic_top dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .power_fail_request_i(flags[0]),
    .ext0_pin_i(flags[1]), .timer0_flag_i(flags[2]), .ext1_pin_i(flags[3]),
    .timer1_flag_i(flags[4]), .serial0_tx_done_flag_i(flags[5]),
    .serial0_rx_done_flag_i(rx_flag), .timer2_flag_i(flags[6]),
    .activity_flag_i(flags[7]), .twowire_flag_i(flags[8]),
    .conversion_done_request_i(flags[9]), .mouse_flag_i(flags[10]),
    .keyboard_flag_i(flags[11]), .pm_input_buffer_full_flag_i(flags[12]),
    .key_detect_flag_i(flags[13]), .watchdog_flag_i(flags[14]),
    .detached_kb_flag_i(flags[15]), .core_ack_i(core_ack_i),
    .core_return_i(core_return_i), .int_req_o(int_req_o),
    .int_vector_o(int_vector_o), .irq_o(irq_o));

  pic_core_model core (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ack_dly_i(ack_dly),
    .ret_go_i(ret_go), .req_i(int_req_o), .vec_i(int_vector_o),
    .ack_o(core_ack_i), .ret_o(core_return_i), .taken_o(taken),
    .taken_vec_o(taken_vec));

  // Shared comparison
  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Wait for the core to take a vector and compare it
  task automatic wait_take(input logic [7:0] exp);
    int n;
    n = 0;
    while (taken !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("taken", 8'h01, {7'h00, taken});
    chk("vector", exp, taken_vec);
  endtask

  // Service routine clears its flag, then returns
  task automatic finish(input int idx);
    @(posedge sys_clk_i);
    flags[idx] <= 1'b0;
    rx_flag    <= 1'b0;
    ret_go     <= 1'b1;
    @(posedge sys_clk_i);
    ret_go <= 1'b0;
  endtask

  // No request may reach the core for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      if (int_req_o !== 1'b0) seen = 1'b1;
    end
    chk("no request", 8'h00, {7'h00, seen});
  endtask

  // Every source at once; expected order from levels and rank
  task automatic t_order(input logic [7:0] bpri, epri, input logic pf);
    logic hi;
    logic [7:0] d;
    ack_dly <= 4'h8;
    wr(`PIC_ADR_ISTAT, 8'hFF);
    wr(`PIC_ADR_BASE_EN, 8'h7F);
    wr(`PIC_ADR_EXT_EN, 8'hFF);
    wr(`PIC_ADR_BASE_PRI, bpri);
    wr(`PIC_ADR_EXT_PRI, epri);
    wr(`PIC_ADR_CTRL, {7'h00, pf});
    @(posedge sys_clk_i);
    flags <= {15'h7FFF, pf};
    if (pf) begin
      wait_take(VTAB[0]);
      rd(`PIC_ADR_ISTAT, d);
      chk("power fail status", 8'h03, d);
      finish(0);
    end
    for (int lv = 1; lv >= 0; lv--) begin
      for (int i = 1; i < 16; i++) begin
        hi = (i < 8) ? bpri[i-1] : epri[i-8];
        if (hi == lv[0]) begin
          wait_take(VTAB[i]);
          finish(i);
        end
      end
    end
    ack_dly <= 4'h0;
    $display("order test done");
  endtask

  // Reset values, bit 7 of base enable register, unmapped offsets
  task automatic t_regs;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk("reset value", 8'h00, d);
    end
    wr(`PIC_ADR_BASE_EN, 8'hFF);
    rd(`PIC_ADR_BASE_EN, d);
    chk("base enable", 8'h7F, d);
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk("unmapped", 8'h00, d);
    wr(`PIC_ADR_BASE_EN, 8'h00);
    $display("register test done");
  endtask

  // Serial request from receive side alone
  task automatic t_serial;
    wr(`PIC_ADR_BASE_EN, 8'h10);
    @(posedge sys_clk_i);
    rx_flag <= 1'b1;
    wait_take(8'h23);
    finish(5);
    $display("serial test done");
  endtask

  // Nesting: same level blocked, higher level preempts
  task automatic t_nest;
    logic [7:0] d;
    wr(`PIC_ADR_CTRL, 8'h00);
    wr(`PIC_ADR_EXT_EN, 8'h00);
    wr(`PIC_ADR_BASE_EN, 8'h0B);
    wr(`PIC_ADR_BASE_PRI, 8'h08);
    @(posedge sys_clk_i);
    flags[2] <= 1'b1;
    wait_take(8'h0B);
    @(posedge sys_clk_i);
    flags[1] <= 1'b1;
    quiet(8);
    @(posedge sys_clk_i);
    flags[4] <= 1'b1;
    wait_take(8'h1B);
    rd(`PIC_ADR_ACTIVE, d);
    chk("active source", 8'h14, d);
    rd(`PIC_ADR_SVC, d);
    chk("in service", 8'h03, d);
    finish(4);
    quiet(8);
    finish(2);
    wait_take(8'h03);
    finish(1);
    $display("nesting test done");
  endtask

  // Enable gating, status, mask and interrupt level
  task automatic t_irq;
    logic [7:0] d;
    wr(`PIC_ADR_ISTAT, 8'hFF);
    wr(`PIC_ADR_IMASK, 8'h01);
    wr(`PIC_ADR_BASE_EN, 8'h00);
    @(posedge sys_clk_i);
    flags[6] <= 1'b1;
    quiet(8);
    wr(`PIC_ADR_BASE_EN, 8'h20);
    wait_take(8'h2B);
    finish(6);
    rd(`PIC_ADR_ISTAT, d);
    chk("status", 8'h01, d);
    chk("irq set", 8'h01, {7'h00, irq_o});
    wr(`PIC_ADR_ISTAT, 8'h01);
    @(posedge sys_clk_i);
    #1;
    chk("irq cleared", 8'h00, {7'h00, irq_o});
    @(posedge sys_clk_i);
    ret_go <= 1'b1;
    @(posedge sys_clk_i);
    ret_go <= 1'b0;
    rd(`PIC_ADR_ISTAT, d);
    chk("spurious", 8'h04, d);
    chk("irq masked", 8'h00, {7'h00, irq_o});
    wr(`PIC_ADR_IMASK, 8'h04);
    @(posedge sys_clk_i);
    #1;
    chk("irq unmasked", 8'h01, {7'h00, irq_o});
    $display("interrupt test done");
  endtask

  // Verdict
  task automatic conclude;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_serial;
    t_order(8'h00, 8'h00, 1'b1);
    t_order(8'h00, 8'h02, 1'b0);
    t_order(8'h00, 8'h10, 1'b0);
    t_order(8'h7F, 8'hFF, 1'b1);
    t_order(8'h55, 8'hAA, 1'b0);
    t_nest;
    t_irq;
    conclude;
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    conclude;
  end
endmodule
